// file: verilog/wreg_ctx_defs.vh
// constants for the working register file with alternate context sets
// assumes inclusion by bare name from each design file
`ifndef WREG_CTX_DEFS_VH
`define WREG_CTX_DEFS_VH

// ----------------------------------------------------------------
// apb register map (byte addresses)
// ----------------------------------------------------------------
`define ADDR_CONFIG_WORD 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_PC 12'h008
`define ADDR_CONTROL 12'h00c
`define ADDR_EXEC_STATUS 12'h010
`define ADDR_WREG_BASE 12'h040
`define ADDR_WREG_TOP 12'h07c

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define BIND_W 3
`define BIND0_LSB 0
`define BIND1_LSB 4
`define BIND2_LSB 8
`define BIND3_LSB 12
`define CFG_RESET 16'h0000
`define STAT_ACTIVE_LSB 0
`define STAT_MANUAL_LSB 8
`define PC_W 23
`define PC_RESET 23'h000000
`define INSTR_W 24
`define DATA_W 16
`define NUM_WREG 16
`define NUM_SHADOW 15
`define NUM_SETS 5
`define SP_INDEX 4'hf
`define SET_PRIMARY 3'h0
`define SP_RESET 16'h1000
`define CTX_DEPTH 8

// ----------------------------------------------------------------
// opcode classes (top byte, or top nibble for families, of the instruction word)
// ----------------------------------------------------------------
`define OPC_SWAP 8'hfe
`define OPC_LOOP 8'h08
`define OPC_REPEAT 8'h09
`define OPC_BRANCH_HI4 4'h3
`define OPC_DMOVE 8'hbe
`define OPC_TABLE_HI4 4'hb
`define STALL_BRANCH 2'h1
`define STALL_DMOVE 2'h1
`define STALL_TABLE 2'h2

`endif

// file: verilog/ctx_return_stack.v
// small stack of register set indexes saved on automatic set switches
// assumes pushes and pops never arrive in the same cycle
`timescale 1ns/1ps
`include "wreg_ctx_defs.vh"

module ctx_return_stack (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // stack operations
    input wire push,
    input wire pop,
    input wire [2:0] push_val,
    output wire [2:0] top_val,
    output wire empty
);

reg [2:0] mem_q [0:7];
reg [3:0] cnt_q;
wire [2:0] wr_idx;
wire [2:0] rd_idx;
genvar g;

assign wr_idx = cnt_q[2:0];
assign rd_idx = cnt_q[2:0] - 3'h1;
assign top_val = mem_q[rd_idx];
assign empty = (cnt_q == 4'h0);

// ----------------------------------------------------------------
// storage, one flip-flop group per entry
// ----------------------------------------------------------------
generate
    for (g = 0; g < `CTX_DEPTH; g = g + 1) begin : g_ent
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mem_q[g] <= `SET_PRIMARY;
            end else if (push && wr_idx == g && cnt_q != 4'h8) begin
                mem_q[g] <= push_val;
            end
        end
    end
endgenerate

// depth counter; overflow drops the push rather than wrapping
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cnt_q <= 4'h0;
    end else if (push && cnt_q != 4'h8) begin
        cnt_q <= cnt_q + 4'h1;
    end else if (pop && !empty) begin
        cnt_q <= cnt_q - 4'h1;
    end
end

endmodule // ctx_return_stack

// file: verilog/wreg_ctx_file.v
// working register file with four alternate context sets and a pc
// assumes a pipeline drives read/write ports and an apb master for config
`timescale 1ns/1ps
`include "wreg_ctx_defs.vh"

module wreg_ctx_file (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // pipeline register access
    input wire [3:0] rd_a_idx,
    input wire [3:0] rd_b_idx,
    input wire wr_en,
    input wire [3:0] wr_idx,
    input wire [15:0] wr_data,
    output reg [15:0] rd_a_data,
    output reg [15:0] rd_b_data,
    // instruction stream
    input wire instr_valid,
    input wire [23:0] instr_word,
    input wire branch_en,
    input wire [22:0] branch_target,
    input wire [15:0] loop_count,
    output reg [22:0] prog_addr,
    output reg stall,
    output reg prog_data_read,
    // interrupt controller
    input wire irq_take,
    input wire [2:0] irq_level,
    input wire irq_return,
    output reg [2:0] active_set_index,
    output reg [2:0] last_manual_set_index
);

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg [15:0] sets_q [0:74];
reg [15:0] stack_ptr_q;
reg [15:0] alt_set_config_word_q;
reg [2:0] act_q;
reg [2:0] man_q;
reg [22:0] pc_q;
reg [1:0] stall_cnt_q;
reg [15:0] rep_cnt_q;
reg [22:0] loop_start_q;
reg loop_act_q;
reg [22:0] saved_pc_q;
reg int_nest_q;
reg [2:0] bind_hit;
reg bind_found;
reg [31:0] rdata_d;
reg rd_err_d;
wire [2:0] stk_top;
wire stk_empty;
wire [7:0] opc;
wire is_swap;
wire is_loop;
wire is_repeat;
wire is_branch;
wire is_dmove;
wire is_table;
wire apb_setup;
wire apb_wr;
wire wreg_hit;
wire [3:0] apb_widx;
wire auto_switch;
wire [2:0] next_set;

assign apb_setup = psel && !penable;
assign apb_wr = psel && penable && pready && pwrite;
assign wreg_hit = paddr >= `ADDR_WREG_BASE && paddr <= `ADDR_WREG_TOP;
assign apb_widx = paddr[5:2];

// variable-length opcode: top byte, or top nibble for families
assign opc = instr_word[23:16];
assign is_swap = instr_valid && opc == `OPC_SWAP;
assign is_loop = instr_valid && opc == `OPC_LOOP;
assign is_repeat = instr_valid && opc == `OPC_REPEAT;
assign is_dmove = instr_valid && opc == `OPC_DMOVE;
assign is_branch = instr_valid && opc[7:4] == `OPC_BRANCH_HI4;
assign is_table = instr_valid && !is_dmove && opc[7:4] == `OPC_TABLE_HI4;

// ----------------------------------------------------------------
// level binding lookup
// ----------------------------------------------------------------
// level zero never binds, so an all-zero config leaves the primary set
always @* begin
    bind_hit = `SET_PRIMARY;
    bind_found = 1'b0;
    if (irq_level != 3'h0) begin
        if (alt_set_config_word_q[`BIND3_LSB +: `BIND_W] == irq_level) begin
            bind_hit = 3'h4;
            bind_found = 1'b1;
        end
        if (alt_set_config_word_q[`BIND2_LSB +: `BIND_W] == irq_level) begin
            bind_hit = 3'h3;
            bind_found = 1'b1;
        end
        if (alt_set_config_word_q[`BIND1_LSB +: `BIND_W] == irq_level) begin
            bind_hit = 3'h2;
            bind_found = 1'b1;
        end
        if (alt_set_config_word_q[`BIND0_LSB +: `BIND_W] == irq_level) begin
            bind_hit = 3'h1;
            bind_found = 1'b1;
        end
    end
end

assign auto_switch = irq_take && bind_found;

ctx_return_stack u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .push(auto_switch),
    .pop(irq_return && !irq_take),
    .push_val(act_q),
    .top_val(stk_top),
    .empty(stk_empty)
);

// priority: interrupt entry, then return, then swap instruction
assign next_set = auto_switch ? bind_hit :
    (irq_return && !stk_empty) ? stk_top :
    (is_swap && instr_word[2:0] < 3'h5) ? instr_word[2:0] : act_q;

// ----------------------------------------------------------------
// context selection and status
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        act_q <= `SET_PRIMARY;
        man_q <= `SET_PRIMARY;
        active_set_index <= `SET_PRIMARY;
        last_manual_set_index <= `SET_PRIMARY;
    end else begin
        act_q <= next_set;
        active_set_index <= next_set;
        if (!auto_switch && !irq_return && is_swap && instr_word[2:0] < 3'h5) begin
            man_q <= instr_word[2:0];
            last_manual_set_index <= instr_word[2:0];
        end
    end
end

// ----------------------------------------------------------------
// register storage
// ----------------------------------------------------------------
// each set keeps its own flops, nothing is copied on a switch
genvar g;
generate
    for (g = 0; g < 75; g = g + 1) begin : g_reg
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sets_q[g] <= 16'h0000;
            end else if (wr_en && wr_idx != `SP_INDEX && act_q * 15 + wr_idx == g) begin
                sets_q[g] <= wr_data;
            end else if (apb_wr && wreg_hit && apb_widx != `SP_INDEX &&
                         act_q * 15 + apb_widx == g) begin
                sets_q[g] <= pwdata[15:0];
            end
        end
    end
endgenerate

// one stack pointer shared by every set
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        stack_ptr_q <= `SP_RESET;
    end else if (wr_en && wr_idx == `SP_INDEX) begin
        stack_ptr_q <= wr_data;
    end else if (apb_wr && wreg_hit && apb_widx == `SP_INDEX) begin
        stack_ptr_q <= pwdata[15:0];
    end
end

// registered operand reads, write-through not provided
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rd_a_data <= 16'h0000;
        rd_b_data <= 16'h0000;
    end else begin
        rd_a_data <= (rd_a_idx == `SP_INDEX) ? stack_ptr_q :
            sets_q[act_q * 15 + rd_a_idx];
        rd_b_data <= (rd_b_idx == `SP_INDEX) ? stack_ptr_q :
            sets_q[act_q * 15 + rd_b_idx];
    end
end

// ----------------------------------------------------------------
// program counter, stalls and hardware loops
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pc_q <= `PC_RESET;
        prog_addr <= `PC_RESET;
        stall <= 1'b0;
        stall_cnt_q <= 2'h0;
        prog_data_read <= 1'b0;
        rep_cnt_q <= 16'h0000;
        loop_start_q <= `PC_RESET;
        loop_act_q <= 1'b0;
        saved_pc_q <= `PC_RESET;
        int_nest_q <= 1'b0;
    end else begin
        prog_data_read <= is_table || is_dmove;
        if (irq_take) begin
            // loop state stays put so the loop resumes on return
            saved_pc_q <= pc_q;
            int_nest_q <= 1'b1;
            stall <= 1'b0;
            stall_cnt_q <= 2'h0;
        end else if (irq_return && int_nest_q) begin
            pc_q <= saved_pc_q;
            prog_addr <= saved_pc_q;
            int_nest_q <= 1'b0;
        end else if (stall_cnt_q != 2'h0) begin
            stall_cnt_q <= stall_cnt_q - 2'h1;
            stall <= stall_cnt_q != 2'h1;
        end else if (branch_en && is_branch) begin
            pc_q <= branch_target;
            prog_addr <= branch_target;
            stall_cnt_q <= `STALL_BRANCH;
            stall <= 1'b1;
        end else if (is_dmove || is_table) begin
            stall_cnt_q <= is_table ? `STALL_TABLE : `STALL_DMOVE;
            stall <= 1'b1;
            pc_q <= pc_q + 23'h000001;
            prog_addr <= pc_q + 23'h000001;
        end else if (is_repeat) begin
            rep_cnt_q <= loop_count;
        end else if (rep_cnt_q != 16'h0000) begin
            rep_cnt_q <= rep_cnt_q - 16'h0001; // pc held, no gap cycle
        end else if (is_loop) begin
            loop_start_q <= pc_q + 23'h000001;
            loop_act_q <= loop_count != 16'h0000;
            rep_cnt_q <= 16'h0000;
            pc_q <= pc_q + 23'h000001;
            prog_addr <= pc_q + 23'h000001;
        end else if (loop_act_q && instr_word[15:0] == 16'h0000 && instr_valid) begin
            // zero-overhead jump back to loop top
            pc_q <= loop_start_q;
            prog_addr <= loop_start_q;
            loop_act_q <= 1'b0;
        end else begin
            pc_q <= pc_q + 23'h000001;
            prog_addr <= pc_q + 23'h000001;
        end
    end
end

// ----------------------------------------------------------------
// apb read mux and answer
// ----------------------------------------------------------------
always @* begin
    rdata_d = 32'h00000000;
    rd_err_d = 1'b0;
    case (paddr)
        `ADDR_CONFIG_WORD: rdata_d = {16'h0000, alt_set_config_word_q};
        `ADDR_STATUS: rdata_d = {21'h000000, man_q, 5'h00, act_q};
        `ADDR_PC: rdata_d = {9'h000, pc_q};
        `ADDR_CONTROL: rdata_d = {16'h0000, rep_cnt_q};
        `ADDR_EXEC_STATUS: rdata_d = {29'h00000000, int_nest_q, loop_act_q, stall};
        default: begin
            if (wreg_hit) begin
                rdata_d = {16'h0000, (apb_widx == `SP_INDEX) ? stack_ptr_q :
                    sets_q[act_q * 15 + apb_widx]};
            end else begin
                rd_err_d = 1'b1;
            end
        end
    endcase
end

// no wait state: setup, then pready in the first access cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
        alt_set_config_word_q <= `CFG_RESET;
    end else begin
        pready <= apb_setup;
        if (apb_setup) begin
            prdata <= pwrite ? 32'h00000000 : rdata_d;
            pslverr <= rd_err_d || (pwrite && paddr != `ADDR_CONFIG_WORD && !wreg_hit);
        end else begin
            pslverr <= 1'b0;
        end
        if (apb_wr && paddr == `ADDR_CONFIG_WORD) begin
            alt_set_config_word_q <= pwdata[15:0] & 16'h7777;
        end
    end
end

endmodule // wreg_ctx_file

// file: verif/wreg_ctx_file_sva.sv
// checker for context switching, flow stalls and apb answers
// assumes one clock domain and the asynchronous low reset of the block
`timescale 1ns/1ps
module wreg_ctx_file_sva (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb side
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire pready,
    input wire pslverr,
    // pipeline and interrupt side
    input wire instr_valid,
    input wire [23:0] instr_word,
    input wire branch_en,
    input wire stall,
    input wire prog_data_read,
    input wire irq_take,
    input wire irq_return,
    input wire [2:0] active_set_index,
    input wire [2:0] last_manual_set_index
);
    // ------------------------------
    // properties
    // ------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // decodes kept apart so the priority terms read plainly
    wire swap_w = instr_valid && instr_word[23:16] == 8'hfe;
    wire setup_w = psel && !penable;
    sequence s_auto_switch;
        irq_take ##1
        (irq_return && !irq_take && active_set_index != $past(active_set_index));
    endsequence
    property p_reset_idx;
        $rose(presetn) |-> active_set_index == 3'h0 && last_manual_set_index == 3'h0;
    endproperty
    property p_swap;
        swap_w && instr_word[2:0] <= 3'h4 && !irq_take && !irq_return |=>
        active_set_index == $past(instr_word[2:0]) && last_manual_set_index == active_set_index;
    endproperty
    property p_manual_cause;
        !$stable(last_manual_set_index) |-> $past(swap_w);
    endproperty
    property p_set_cause;
        !$stable(active_set_index) |-> $past(irq_take || irq_return || swap_w);
    endproperty
    // a return right after an automatic switch must undo it
    property p_return;
        s_auto_switch |=> active_set_index == $past(active_set_index, 2);
    endproperty
    property p_apb_ready;
        setup_w |=> pready ##1 !pready;
    endproperty
    property p_ro_status;
        setup_w && pwrite && paddr == 12'h004 |=> pready && pslverr;
    endproperty
    property p_branch_stall;
        instr_valid && instr_word[23:20] == 4'h3 && branch_en && !stall |=> stall;
    endproperty
    property p_table_read;
        instr_valid && instr_word[23:20] == 4'hb && !stall |=> prog_data_read;
    endproperty
    a_reset_idx: assert property (p_reset_idx) else $error("status not zero");
    a_swap: assert property (p_swap) else $error("swap did not select set");
    a_manual_cause: assert property (p_manual_cause) else $error("manual index moved");
    a_set_cause: assert property (p_set_cause) else $error("set changed alone");
    a_return: assert property (p_return) else $error("set not restored");
    a_apb_ready: assert property (p_apb_ready) else $error("pready timing");
    a_ro_status: assert property (p_ro_status) else $error("status write taken");
    a_branch_stall: assert property (p_branch_stall) else $error("no branch stall");
    a_table_read: assert property (p_table_read) else $error("no program read");
endmodule // wreg_ctx_file_sva

bind wreg_ctx_file wreg_ctx_file_sva wreg_ctx_file_sva_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
    .branch_en(branch_en), .stall(stall), .prog_data_read(prog_data_read),
    .irq_take(irq_take), .irq_return(irq_return), .active_set_index(active_set_index),
    .last_manual_set_index(last_manual_set_index));

// file: verif/ctx_partner.sv
// model of the instruction pipeline and interrupt controller
// assumes the bench calls its tasks right after a rising edge
`timescale 1ns/1ps
module ctx_partner (
    // clock
    input wire pclk,
    // instruction stream
    output reg instr_valid,
    output reg [23:0] instr_word,
    output reg branch_en,
    output reg [22:0] branch_target,
    output reg [15:0] loop_count,
    // interrupt side
    output reg irq_take,
    output reg [2:0] irq_level,
    output reg irq_return
);
    // ------------------------------
    // drivers
    // ------------------------------
    initial begin
        {instr_valid, branch_en, irq_take, irq_return} = 4'h0;
        instr_word = 24'h000000;
        branch_target = 23'h000000;
        loop_count = 16'h0003;
        irq_level = 3'h0;
    end
    // released word is inverted so a stale value is never mistaken for a live one
    task issue(input [23:0] w, input b, input [22:0] t);
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr_word <= w;
        branch_en <= b;
        branch_target <= t;
        @(posedge pclk);
        instr_valid <= 1'b0;
        instr_word <= ~w;
        branch_en <= 1'b0;
    endtask
    task take(input [2:0] lvl);
        @(posedge pclk);
        irq_take <= 1'b1;
        irq_level <= lvl;
        @(posedge pclk);
        irq_take <= 1'b0;
        irq_level <= ~lvl;
    endtask
    // no leading wait, so a call straight after take gives a back-to-back return
    task ret;
        irq_return <= 1'b1;
        @(posedge pclk);
        irq_return <= 1'b0;
    endtask
endmodule // ctx_partner

// file: verif/tb.sv
// self-checking bench for the working register file
// assumes the checker is bound and the partner drives the pipeline side
`timescale 1ns/1ps
module tb;
    reg pclk, presetn, psel, penable, pwrite, wr_en, rerr;
    reg [11:0] paddr;
    reg [31:0] pwdata, rdat;
    reg [3:0] rd_idx, wr_idx;
    reg [15:0] wr_data;
    wire [31:0] prdata;
    wire pready, pslverr, stall, prog_data_read, instr_valid, branch_en, irq_take, irq_return;
    wire [15:0] rd_a_data, rd_b_data, loop_count;
    wire [23:0] instr_word;
    wire [22:0] prog_addr, branch_target;
    wire [2:0] active_set_index, last_manual_set_index, irq_level;
    integer n_fail = 0;
    integer compares = 0;
    integer s;
    wreg_ctx_file wreg_ctx_file_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rd_a_idx(rd_idx), .rd_b_idx(rd_idx),
        .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .rd_a_data(rd_a_data),
        .rd_b_data(rd_b_data), .instr_valid(instr_valid), .instr_word(instr_word),
        .branch_en(branch_en), .branch_target(branch_target), .loop_count(loop_count),
        .prog_addr(prog_addr), .stall(stall), .prog_data_read(prog_data_read),
        .irq_take(irq_take), .irq_level(irq_level), .irq_return(irq_return),
        .active_set_index(active_set_index), .last_manual_set_index(last_manual_set_index));
    ctx_partner ctx_partner_i (.pclk(pclk), .instr_valid(instr_valid), .instr_word(instr_word),
        .branch_en(branch_en), .branch_target(branch_target), .loop_count(loop_count),
        .irq_take(irq_take), .irq_level(irq_level), .irq_return(irq_return));
    // ------------------------------
    // helpers
    // ------------------------------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task chk(input string what, input [31:0] exp, input [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // bounded wait, a missing pready counts as a mismatch
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        chk("pready", 1, pready);
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task wr(input [3:0] i, input [15:0] d);
        @(posedge pclk);
        {wr_en, wr_idx, wr_data} <= {1'b1, i, d};
        @(posedge pclk);
        wr_en <= 1'b0;
    endtask
    task rd(input [3:0] i, input [15:0] e);
        @(posedge pclk);
        rd_idx <= i;
        @(posedge pclk);
        #1 chk("rd_a", e, rd_a_data);
        chk("rd_b", e, rd_b_data);
    endtask
    task sets(input [2:0] a, input [2:0] m);
        #1 chk("active", a, active_set_index);
        chk("manual", m, last_manual_set_index);
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    task t_reset;
        sets(0, 0);
        rd(15, 16'h1000);
        apb(0, 12'h004, 0);
        chk("status", 0, rdat);
        $display("reset test done");
    endtask
    task t_apb;
        apb(1, 12'h000, 32'h7500);
        apb(0, 12'h000, 0);
        chk("config", 32'h7500, rdat);
        apb(1, 12'h004, 32'h0101);
        chk("status_wr_err", 1, rerr);
        apb(0, 12'h020, 0);
        chk("unmapped_err", 1, rerr);
        $display("apb test done");
    endtask
    task t_sets;
        wr(0, 16'h1111);
        wr(15, 16'h2222);
        for (s = 1; s <= 4; s++) begin
            ctx_partner_i.issue(24'hfe0000 | s, 0, 0);
            sets(s, s);
            wr(0, 16'ha000 + s);
        end
        apb(0, 12'h004, 0);
        chk("status", 32'h0404, rdat);
        ctx_partner_i.issue(24'hfe0006, 0, 0);
        sets(4, 4);
        for (s = 0; s <= 4; s++) begin
            ctx_partner_i.issue(24'hfe0000 | s, 0, 0);
            rd(0, s == 0 ? 16'h1111 : 16'ha000 + s);
            rd(15, 16'h2222);
        end
        apb(0, 12'h07c, 0);
        chk("wreg15", 32'h2222, rdat);
        $display("sets test done");
    endtask
    task t_irq;
        ctx_partner_i.take(5);
        sets(3, 4);
        ctx_partner_i.take(7);
        sets(4, 4);
        rd(0, 16'ha004);
        @(posedge pclk);
        ctx_partner_i.ret();
        sets(3, 4);
        @(posedge pclk);
        ctx_partner_i.ret();
        sets(4, 4);
        ctx_partner_i.take(3);
        sets(4, 4);
        ctx_partner_i.take(5);
        ctx_partner_i.ret();
        sets(4, 4);
        $display("irq test done");
    endtask
    // branch, loop end, repeat hold, then long moves; pc tracked from the branch target
    task t_flow;
        ctx_partner_i.issue(24'h300000, 1, 23'h001234);
        #1 chk("pc", 23'h001234, prog_addr);
        chk("branch_stall", 1, stall);
        ctx_partner_i.issue(24'h080000, 0, 0);
        ctx_partner_i.issue(24'h000000, 0, 0);
        #1 chk("loop_top", 23'h001235, prog_addr);
        ctx_partner_i.issue(24'h090000, 0, 0);
        repeat (2) @(posedge pclk);
        #1 chk("repeat_hold", 23'h001236, prog_addr);
        ctx_partner_i.issue(24'hbe0000, 0, 0);
        #1 chk("dmove_pc", 23'h001237, prog_addr);
        chk("dmove_read", 1, prog_data_read);
        ctx_partner_i.issue(24'hb10000, 0, 0);
        #1 chk("table_read", 1, prog_data_read);
        chk("table_stall", 1, stall);
        @(posedge pclk);
        #1 chk("table_stall2", 1, stall);
        chk("read_pulse", 0, prog_data_read);
        @(posedge pclk);
        #1 chk("stall_end", 0, stall);
        $display("flow test done");
    endtask
    // ------------------------------
    // main sequence and watchdog
    // ------------------------------
    initial begin
        {presetn, psel, penable, pwrite, wr_en} = 5'h00;
        {paddr, pwdata, rd_idx, wr_idx, wr_data} = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_apb();
        t_sets();
        t_irq();
        t_flow();
        summarize();
    end
    initial begin
        #(100 * 5000);
        n_fail++;
        summarize();
    end
endmodule // tb
